/* File: hdl/apsr_regs.sv */
// segment amplitude register bank with APB slave and segment sequencer
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module apsr_regs
	import apsr_pkg::*;
#(
	parameter int SLOT_CYC = APSR_SLOT_CYC
) (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    clk_en,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [APSR_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// segments one and two from the neighbouring bank
	input  wire logic [APSR_AMP_W-1:0]   seg_one_amplitude,
	input  wire logic [APSR_AMP_W-1:0]   seg_two_amplitude,
	// line driver
	output logic                         arb_active,
	output logic [APSR_SEG_IDX_W-1:0]    seg_idx,
	output logic [APSR_AMP_W-1:0]        amp_magnitude_r,
	output logic                         amp_negative_r,
	output logic                         period_end
);
	typedef enum logic [2:0] {
		APSR_ST_IDLE = 3'b001,
		APSR_ST_RUN  = 3'b010,
		APSR_ST_STOP = 3'b100
	} apsr_state_t;

	localparam int NREG      = 6;
	localparam int SLOT_SEG5 = int'(APSR_IDX_SEG5 - APSR_IDX_SEG3);
	localparam int SLOT_SEG6 = int'(APSR_IDX_SEG6 - APSR_IDX_SEG3);
	localparam int SLOT_SEG7 = int'(APSR_IDX_SEG7 - APSR_IDX_SEG3);
	localparam int SLOT_SEG8 = int'(APSR_IDX_SEG8 - APSR_IDX_SEG3);

	apsr_state_t           state_r;
	apsr_state_t           state_nxt;
	logic [7:0]            seg_r [NREG];
	logic                  arb_mode_r;
	logic [APSR_AMP_W-1:0] amp_sel;
	logic [4:0]            idx;
	logic                  addr_ok;
	logic                  wr_en;
	logic                  rd_en;
	logic                  run;
	// amplitudes of segments five to eight under their field names
	logic [APSR_AMP_W-1:0] seg_five_amplitude;
	logic [APSR_AMP_W-1:0] seg_six_amplitude;
	logic [APSR_AMP_W-1:0] seg_seven_amplitude;
	logic [APSR_AMP_W-1:0] seg_eight_amplitude;

	// byte address -> printed register index
	function automatic logic [4:0] reg_index(input logic [APSR_ADDR_W-1:0] a);
		reg_index = a[APSR_ADDR_LSB +: 5];
	endfunction : reg_index

	// which known register an index names
	function automatic logic idx_mapped(input logic [4:0] i);
		idx_mapped = (i >= APSR_IDX_SEG3 && i <= APSR_IDX_SEG8) ||
			i == APSR_IDX_CTRL || i == APSR_IDX_STAT;
	endfunction : idx_mapped

	assign idx     = reg_index(paddr);
	assign addr_ok = idx_mapped(idx) && (paddr[APSR_ADDR_LSB-1:0] == '0);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en   = clk_en && psel && penable && pwrite && addr_ok;
	assign rd_en   = psel && !penable && !pwrite;

	// amplitude storage; bit 7 reserved and kept zero
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_seg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					seg_r[g] <= APSR_SEG_RESET;
				else if (wr_en && idx == APSR_IDX_SEG3 + 5'(g))
					seg_r[g] <= pwdata[7:0] & APSR_SEG_WMASK;
			end
		end
	endgenerate

	assign seg_five_amplitude  = seg_r[SLOT_SEG5][APSR_AMP_W-1:0];
	assign seg_six_amplitude   = seg_r[SLOT_SEG6][APSR_AMP_W-1:0];
	assign seg_seven_amplitude = seg_r[SLOT_SEG7][APSR_AMP_W-1:0];
	assign seg_eight_amplitude = seg_r[SLOT_SEG8][APSR_AMP_W-1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			arb_mode_r <= 1'b0;
		else if (wr_en && idx == APSR_IDX_CTRL)
			arb_mode_r <= pwdata[APSR_CTRL_ARB_BIT];
	end

	// read data captured in setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= APSR_ZERO32;
		end else if (clk_en && rd_en) begin
			prdata <= APSR_ZERO32;
			if (idx >= APSR_IDX_SEG3 && idx <= APSR_IDX_SEG8)
				prdata[7:0] <= seg_r[3'(idx - APSR_IDX_SEG3)];
			else if (idx == APSR_IDX_CTRL)
				prdata[APSR_CTRL_ARB_BIT] <= arb_mode_r;
			else if (idx == APSR_IDX_STAT)
				prdata[4:0] <= {arb_active, state_r == APSR_ST_RUN, seg_idx};
		end
	end

	// sequencer: starts only in arbitrary mode, stops at the next period boundary after it is left
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			APSR_ST_IDLE: if (arb_mode_r) state_nxt = APSR_ST_RUN;
			APSR_ST_RUN:  if (!arb_mode_r) state_nxt = APSR_ST_STOP;
			APSR_ST_STOP: if (arb_mode_r) state_nxt = APSR_ST_RUN;
				else if (period_end) state_nxt = APSR_ST_IDLE;
			default:      state_nxt = APSR_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_r <= APSR_ST_IDLE;
		else if (clk_en)
			state_r <= state_nxt;
	end

	assign run        = state_r != APSR_ST_IDLE;
	assign arb_active = run;

	apsr_slot_timer #(
		.SLOT_CYC   (SLOT_CYC)
	) u_timer (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (clk_en),
		.run        (run),
		.seg_idx_r  (seg_idx),
		.period_end (period_end)
	);

	// segment select: 0,1 external; 2..7 from this bank
	always_comb begin
		case (seg_idx)
			3'd0:    amp_sel = seg_one_amplitude;
			3'd1:    amp_sel = seg_two_amplitude;
			3'd4:    amp_sel = seg_five_amplitude;
			3'd5:    amp_sel = seg_six_amplitude;
			3'd6:    amp_sel = seg_seven_amplitude;
			3'd7:    amp_sel = seg_eight_amplitude;
			default: amp_sel = seg_r[3'(seg_idx - 3'd2)][APSR_AMP_W-1:0];
		endcase
	end

	// signed magnitude split; zero drive while the sequencer is idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_magnitude_r <= '0;
			amp_negative_r  <= 1'b0;
		end else if (clk_en) begin
			if (run) begin
				amp_magnitude_r <= {1'b0, amp_sel[APSR_SIGN_BIT-1:0]};
				amp_negative_r  <= amp_sel[APSR_SIGN_BIT];
			end else begin
				amp_magnitude_r <= '0;
				amp_negative_r  <= 1'b0;
			end
		end
	end

	chk_mode_gates_out: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !run) |=> (amp_magnitude_r == '0 && !amp_negative_r))
		else $error("output driven outside arbitrary mode");
	chk_seg5_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == APSR_IDX_SEG5) |=> (seg_r[2] == ($past(pwdata[7:0]) & APSR_SEG_WMASK)))
		else $error("segment five write lost");
	chk_seg8_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == APSR_IDX_SEG8) |=> (seg_r[5] == ($past(pwdata[7:0]) & APSR_SEG_WMASK)))
		else $error("segment eight write lost");
	chk_sign_magnitude: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd4) |=> (amp_negative_r == $past(seg_r[2][APSR_SIGN_BIT])
			&& amp_magnitude_r[APSR_SIGN_BIT] == 1'b0))
		else $error("sign/magnitude split wrong");
	chk_seg7_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd6) |=> (amp_magnitude_r[5:0] == $past(seg_r[4][5:0])))
		else $error("segment seven not presented");
	chk_seg6_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd5) |=> (amp_negative_r == $past(seg_r[3][APSR_SIGN_BIT])))
		else $error("segment six not presented");
	chk_seg3_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd2) |=> (amp_magnitude_r[5:0] == $past(seg_r[0][5:0])))
		else $error("segment three not presented");
	chk_seg5_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd4) |=> (amp_magnitude_r[5:0] == $past(seg_five_amplitude[5:0])))
		else $error("segment five not presented");
	chk_seg8_select: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && seg_idx == 3'd7) |=> (amp_negative_r == $past(seg_eight_amplitude[APSR_SIGN_BIT])
			&& amp_magnitude_r[5:0] == $past(seg_eight_amplitude[5:0])))
		else $error("segment eight not presented");
	chk_idx_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && period_end) |=> (seg_idx == 3'd0))
		else $error("index did not wrap after eighth slot");
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(seg_r[0][7] | seg_r[1][7] | seg_r[2][7] | seg_r[3][7] | seg_r[4][7] | seg_r[5][7]) == 1'b0)
		else $error("reserved bit set");

	cov_arb_start: cover property (@(posedge pclk) disable iff (!presetn) state_r == APSR_ST_IDLE ##1 run);
	cov_full_period: cover property (@(posedge pclk) disable iff (!presetn) period_end);
	cov_stop_drain: cover property (@(posedge pclk) disable iff (!presetn) state_r == APSR_ST_STOP);
	cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : apsr_regs

/* File: hdl/apsr_pkg.sv */
// package: register map, field layout and timing constants for the segment amplitude bank
package apsr_pkg;
	// register indices as printed (not multiples of four: byte address = index * 4)
	localparam logic [4:0]  APSR_IDX_SEG3      = 5'h0a;
	localparam logic [4:0]  APSR_IDX_SEG4      = 5'h0b;
	localparam logic [4:0]  APSR_IDX_SEG5      = 5'h0c;
	localparam logic [4:0]  APSR_IDX_SEG6      = 5'h0d;
	localparam logic [4:0]  APSR_IDX_SEG7      = 5'h0e;
	localparam logic [4:0]  APSR_IDX_SEG8      = 5'h0f;
	localparam logic [4:0]  APSR_IDX_CTRL      = 5'h14;
	localparam logic [4:0]  APSR_IDX_STAT      = 5'h15;
	localparam int          APSR_ADDR_LSB      = 2;
	localparam int          APSR_ADDR_W        = 8;
	localparam logic [7:0]  APSR_SEG_RESET     = 8'h00;
	localparam logic [7:0]  APSR_SEG_WMASK     = 8'h7f;
	localparam int          APSR_AMP_W         = 7;
	localparam int          APSR_SIGN_BIT      = 6;
	localparam int          APSR_NSEG          = 8;
	localparam int          APSR_SEG_IDX_W     = 3;
	localparam int          APSR_CTRL_ARB_BIT  = 0;
	localparam logic [31:0] APSR_ZERO32        = 32'h0000_0000;
	// default master-clock period and slot length
	localparam int          APSR_MCLK_NS       = 640;
	localparam int          APSR_PCLK_NS       = 10;
	localparam int          APSR_SLOT_CYC      = (APSR_MCLK_NS / APSR_NSEG) / APSR_PCLK_NS;
	localparam int          APSR_SLOT_W        = 16;
	typedef logic [APSR_AMP_W-1:0] apsr_amp_t;
endpackage : apsr_pkg

/* File: hdl/apsr_slot_timer.sv */
// slot timer: steps the segment index once per eighth of a master-clock period
`timescale 1ns/10ps
module apsr_slot_timer
	import apsr_pkg::*;
#(
	parameter int SLOT_CYC = APSR_SLOT_CYC
) (
	// clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      clk_en,
	// control
	input  wire logic                      run,
	// status
	output logic [APSR_SEG_IDX_W-1:0]      seg_idx_r,
	output logic                           period_end
);
	localparam logic [APSR_SLOT_W-1:0] SLOT_LAST = APSR_SLOT_W'(SLOT_CYC - 1);

	logic [APSR_SLOT_W-1:0] slot_cnt_r;
	logic                   slot_done;

	assign slot_done  = run && (slot_cnt_r == SLOT_LAST);
	assign period_end = slot_done && (seg_idx_r == APSR_SEG_IDX_W'(APSR_NSEG - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt_r <= '0;
		end else if (clk_en) begin
			if (!run || slot_done)
				slot_cnt_r <= '0;
			else
				slot_cnt_r <= slot_cnt_r + 1'b1;
		end
	end

	// eight equal slots fill one period; index wraps 7 -> 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_idx_r <= '0;
		end else if (clk_en) begin
			if (!run)
				seg_idx_r <= '0;
			else if (slot_done)
				seg_idx_r <= seg_idx_r + 1'b1;
		end
	end

	chk_slot_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
		run |-> (slot_cnt_r <= SLOT_LAST))
		else $error("slot counter out of range");
	chk_idx_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && run && !slot_done) |=> (seg_idx_r == $past(seg_idx_r)))
		else $error("segment index stepped inside a slot");
endmodule : apsr_slot_timer

/* File: dv/tb_arb_pulse_segment_regs_5to8.sv */
// self-checking bench for the segment amplitude bank
`timescale 1ns/10ps
module tb_arb_pulse_segment_regs_5to8 import apsr_pkg::*;;
	localparam int SLOT = 2;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic        arb_active, amp_negative_r, period_end, act_q, e, en_q;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [6:0]  s1, s2, amp_magnitude_r, exp_now;
	logic [2:0]  seg_idx, idx_q;
	logic [6:0]  exp_amp [8];
	int          fails, checks_done, cyc, last_pe, npe;

	apsr_regs #(.SLOT_CYC(SLOT)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .seg_one_amplitude(s1), .seg_two_amplitude(s2),
		.arb_active(arb_active), .seg_idx(seg_idx), .amp_magnitude_r(amp_magnitude_r),
		.amp_negative_r(amp_negative_r), .period_end(period_end));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : cmp

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic summarize;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// line-side model: amplitude lags the index by one enabled edge
	always @(negedge pclk) begin
		if (presetn) begin
			if (en_q) begin
				cyc++;
				exp_now = act_q ? exp_amp[idx_q] : 7'h00;
				if (seg_idx !== idx_q) cmp(32'(seg_idx), 32'(3'(idx_q + 3'h1)));
			end else begin
				cmp(32'(seg_idx), 32'(idx_q));
			end
			cmp(32'(amp_magnitude_r), {26'h0, exp_now[5:0]});
			cmp(32'(amp_negative_r), 32'(exp_now[6]));
			if (period_end === 1'b1 && clk_en === 1'b1) begin
				cmp(32'(seg_idx), 32'h0000_0007);
				if (last_pe > 0) cmp(32'(cyc - last_pe), 32'(APSR_NSEG * SLOT));
				last_pe = cyc;
				npe++;
			end
			act_q = arb_active;
			idx_q = seg_idx;
			en_q  = clk_en;
		end
	end

	initial begin
		#200_000;
		fails++;
		summarize;
	end

	initial begin
		int n;
		presetn = 1'b0;
		clk_en  = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		act_q   = 1'b0;
		idx_q   = 3'h0;
		en_q    = 1'b1;
		exp_now = 7'h00;
		void'($urandom(60433));
		s1 = 7'($urandom);
		s2 = 7'($urandom);
		exp_amp[0] = s1;
		exp_amp[1] = s2;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(8'h28 + 4 * i), 32'h0000_0000);
			cmp(r, 32'h0000_0000);
		end
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			exp_amp[i + 2] = v[6:0];
			apb(1'b1, 8'(8'h28 + 4 * i), v);
		end
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(8'h28 + 4 * i), 32'h0000_0000);
			cmp(r, {25'h0, exp_amp[i + 2]});
		end
		apb(1'b1, 8'h40, 32'hffff_ffff);
		cmp(32'(e), 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000);
		cmp(32'(e), 32'h0000_0001);
		cmp(r, 32'h0000_0000);
		apb(1'b1, 8'h31, 32'h0000_007f);
		cmp(32'(e), 32'h0000_0001);
		apb(1'b0, 8'h30, 32'h0000_0000);
		cmp(32'(e), 32'h0000_0000);
		cmp(r, {25'h0, exp_amp[4]});
		apb(1'b1, 8'h50, 32'h0000_0001);
		apb(1'b0, 8'h50, 32'h0000_0000);
		cmp(r, 32'h0000_0001);
		repeat (3 * APSR_NSEG * SLOT + 4) @(posedge pclk);
		clk_en <= 1'b0;
		repeat (5) @(posedge pclk);
		clk_en <= 1'b1;
		repeat (APSR_NSEG * SLOT + 2) @(posedge pclk);
		cmp(32'(npe >= 4), 32'h0000_0001);
		apb(1'b1, 8'h50, 32'h0000_0000);
		n = 0;
		while (arb_active !== 1'b0 && n < 4 * APSR_NSEG * SLOT) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		cmp(32'(arb_active), 32'h0000_0000);
		cmp(32'(amp_magnitude_r), 32'h0000_0000);
		cmp(32'(amp_negative_r), 32'h0000_0000);
		apb(1'b0, 8'h54, 32'h0000_0000);
		cmp(r, 32'h0000_0000);
		summarize;
	end
endmodule : tb_arb_pulse_segment_regs_5to8
